// file: verilog/lslc_top.sv
// Link control register bank with serializer, stereo error check and capture
// Function
// - Two-bit latency delays the output stream
// - Sync enable sends zero word with start
// - Ten-bit mode sends all pixel bits
// - Eight-bit mode adds two control bits
// - Error detection only while enabled
// - Sticky flag holds until cleared
// - Writing clear returns flag to zero unless a new error arrives
// - Flag readable and driven on pin
// - Capture register packs master and slave bytes
// - Capture when master reserved, slave not
// - Gain status, seven bits, resets 0x10
// - Exposure status, sixteen bits, resets 200
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "lslc_cfg.svh"
module lslc_top #(
  parameter int ADDR_W = 12,
  parameter int LAT_DEPTH = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pix_valid,
  output logic pix_ready,
  input wire logic [9:0] pix_data,
  input wire logic [1:0] pix_ctrl,
  input wire logic pix_reserved,
  input wire logic slave_valid,
  input wire logic [7:0] slave_pix,
  input wire logic [1:0] slave_ctrl,
  input wire logic slave_reserved,
  input wire logic gain_valid,
  input wire logic [6:0] gain_in,
  input wire logic expo_valid,
  input wire logic [15:0] expo_in,
  output logic serial_data_out,
  output logic stereo_error,
  output logic irq
);

  // -----------------------------------------------------------------
  // Address decode helpers
  // -----------------------------------------------------------------
  // Register index from a byte address
  function automatic logic [7:0] reg_idx(input logic [ADDR_W-1:0] a);
    reg_idx = a[9:2];
  endfunction

  // True for an implemented register
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    logic [7:0] i;
    i = a[9:2];
    is_mapped = (a[ADDR_W-1:10] == '0) &&
      ((i >= `LSLC_IDX_LATENCY && i <= `LSLC_IDX_EXPOSURE) ||
       i == `LSLC_IDX_IRQ_STAT || i == `LSLC_IDX_IRQ_MASK);
  endfunction

  // -----------------------------------------------------------------
  // Register state
  // -----------------------------------------------------------------
  lslc_pkg::lslc_lat_t lat_q; // Stream latency
  logic sync_en_q; // Internal sync enable
  lslc_pkg::lslc_fmt_t fmt_q; // Payload format
  logic det_en_q; // Stereo detect enable
  logic sticky_q; // Sticky flag mode
  logic clear_q; // One-cycle clear pulse
  logic flag_q; // Stereo error flag
  logic [15:0] cap_q; // Master and slave bytes
  logic [6:0] gain_q; // Gain status
  logic [15:0] expo_q; // Exposure status
  logic [1:0] irq_stat_q; // Sticky event bits
  logic [1:0] irq_mask_q; // Event mask
  logic aw_hold_q; // Write address taken
  logic w_hold_q; // Write data taken
  logic [ADDR_W-1:0] awaddr_q; // Held write address
  logic [31:0] wdata_q; // Held write data
  logic [3:0] wstrb_q; // Held byte strobes
  logic bvalid_q; // Write answer pending
  logic [1:0] bresp_q; // Write answer code
  logic rvalid_q; // Read answer pending
  logic [1:0] rresp_q; // Read answer code
  logic [31:0] rdata_q; // Read answer data

  // -----------------------------------------------------------------
  // AXI4-Lite write path
  // -----------------------------------------------------------------
  logic wr_go; // Both halves present, answer free
  logic rd_go; // Read address taken
  logic [7:0] wr_idx; // Decoded write index
  logic stat_rd; // Read of event status

  assign s_axi_awready = ce && !aw_hold_q && !bvalid_q;
  assign s_axi_wready = ce && !w_hold_q && !bvalid_q;
  assign wr_go = ce && aw_hold_q && w_hold_q && !bvalid_q;
  assign wr_idx = reg_idx(awaddr_q);
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // Write address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_hold_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_go) begin
        w_hold_q <= 1'b0;
      end
    end
  end

  // Write answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= `LSLC_RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= is_mapped(awaddr_q) ? `LSLC_RESP_OKAY : `LSLC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Control registers, low byte lane only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lat_q <= 2'h0;
      sync_en_q <= 1'b0;
      fmt_q <= lslc_pkg::LSLC_FMT_8_PLUS_CTRL;
      det_en_q <= 1'b0;
      sticky_q <= 1'b0;
      clear_q <= 1'b0;
      irq_mask_q <= 2'h0;
    end else if (ce) begin
      clear_q <= 1'b0;
      if (wr_go && wstrb_q[0]) begin
        case (wr_idx)
          `LSLC_IDX_LATENCY: lat_q <= wdata_q[`LSLC_LAT_MSB:0];
          `LSLC_IDX_SYNC: sync_en_q <= wdata_q[`LSLC_BIT_SYNC_EN];
          `LSLC_IDX_PAYLOAD: begin
            fmt_q <= lslc_pkg::lslc_fmt_t'(wdata_q[`LSLC_BIT_TEN_BIT]);
          end
          `LSLC_IDX_ERR_CTRL: begin
            det_en_q <= wdata_q[`LSLC_BIT_DET_EN];
            sticky_q <= wdata_q[`LSLC_BIT_STICKY];
            clear_q <= wdata_q[`LSLC_BIT_CLEAR];
          end
          `LSLC_IDX_IRQ_MASK: irq_mask_q <= wdata_q[1:0];
          default: ;
        endcase
      end
    end
  end

  // -----------------------------------------------------------------
  // AXI4-Lite read path
  // -----------------------------------------------------------------
  assign s_axi_arready = ce && !rvalid_q;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign stat_rd = rd_go && is_mapped(s_axi_araddr) &&
    reg_idx(s_axi_araddr) == `LSLC_IDX_IRQ_STAT;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Read mux into the answer register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q <= `LSLC_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else if (ce) begin
      if (rd_go) begin
        rvalid_q <= 1'b1;
        rresp_q <= is_mapped(s_axi_araddr) ? `LSLC_RESP_OKAY : `LSLC_RESP_SLVERR;
        rdata_q <= 32'h0000_0000;
        if (is_mapped(s_axi_araddr)) begin
          case (reg_idx(s_axi_araddr))
            `LSLC_IDX_LATENCY: rdata_q <= {30'h0, lat_q};
            `LSLC_IDX_SYNC: rdata_q <= {31'h0, sync_en_q};
            `LSLC_IDX_PAYLOAD: rdata_q <= {31'h0, fmt_q};
            `LSLC_IDX_ERR_CTRL: rdata_q <= {29'h0, 1'b0, sticky_q, det_en_q};
            `LSLC_IDX_ERR_FLAG: rdata_q <= {31'h0, flag_q};
            `LSLC_IDX_CAPTURE: rdata_q <= {16'h0, cap_q};
            `LSLC_IDX_GAIN: rdata_q <= {25'h0, gain_q};
            `LSLC_IDX_EXPOSURE: rdata_q <= {16'h0, expo_q};
            `LSLC_IDX_IRQ_STAT: rdata_q <= {30'h0, irq_stat_q};
            `LSLC_IDX_IRQ_MASK: rdata_q <= {30'h0, irq_mask_q};
            default: rdata_q <= 32'h0000_0000;
          endcase
        end
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------
  // Serializer
  // -----------------------------------------------------------------
  lslc_pkg::lslc_ser_state_t ser_q; // Shifting or idle
  logic [3:0] cnt_q; // Bits left in the word
  logic [10:0] sh_q; // Start bit then payload, LSB first
  logic [9:0] payload; // Formatted pixel payload
  logic last_bit; // Word ends this cycle
  logic load; // New word enters
  logic ser_bit; // Undelayed line bit

  assign last_bit = (ser_q == lslc_pkg::LSLC_SER_IDLE) || (cnt_q == 4'h1);
  assign pix_ready = ce && last_bit && !sync_en_q;
  assign load = ce && last_bit && (sync_en_q || pix_valid);
  assign ser_bit = (ser_q == lslc_pkg::LSLC_SER_SHIFT) && sh_q[0];

  // Payload format choice
  always_comb begin
    if (sync_en_q) begin
      payload = `LSLC_SYNC_PAYLOAD;
    end else if (fmt_q == lslc_pkg::LSLC_FMT_10_BIT) begin
      payload = pix_data;
    end else begin
      payload = {pix_ctrl, pix_data[9:2]};
    end
  end

  // Shift register and bit count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ser_q <= lslc_pkg::LSLC_SER_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 11'h000;
    end else if (ce) begin
      if (load) begin
        ser_q <= lslc_pkg::LSLC_SER_SHIFT;
        cnt_q <= `LSLC_WORD_BITS;
        sh_q <= {payload, 1'b1};
      end else if (last_bit) begin
        ser_q <= lslc_pkg::LSLC_SER_IDLE;
        cnt_q <= 4'h0;
      end else begin
        cnt_q <= cnt_q - 4'h1;
        sh_q <= {1'b0, sh_q[10:1]};
      end
    end
  end

  lslc_delay_line #(
    .DEPTH(LAT_DEPTH)
  ) u_delay (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .sel(lat_q),
    .bit_in(ser_bit),
    .bit_out(serial_data_out)
  );

  // -----------------------------------------------------------------
  // Stereo error detection and capture
  // -----------------------------------------------------------------
  logic mismatch; // Control bits disagree now
  logic capture; // Master reserved, slave not

  assign mismatch = det_en_q && pix_valid && slave_valid && (pix_ctrl != slave_ctrl);
  assign capture = pix_valid && slave_valid && pix_reserved && !slave_reserved;
  assign stereo_error = flag_q;

  // Error flag, new error wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= 1'b0;
    end else if (ce) begin
      if (!sticky_q) begin
        flag_q <= mismatch;
      end else if (mismatch) begin
        flag_q <= 1'b1;
      end else if (clear_q) begin
        flag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_q <= 16'h0000;
    end else if (ce && capture) begin
      cap_q <= {pix_data[9:2], slave_pix};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gain_q <= `LSLC_GAIN_RST;
    end else if (ce && gain_valid) begin
      gain_q <= gain_in;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      expo_q <= `LSLC_EXPO_RST;
    end else if (ce && expo_valid) begin
      expo_q <= expo_in;
    end
  end

  // -----------------------------------------------------------------
  // Interrupt status, cleared by read, set wins
  // -----------------------------------------------------------------
  logic [1:0] ev; // Events this cycle

  assign ev = {capture, mismatch};
  assign irq = |(irq_stat_q & irq_mask_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= 2'h0;
    end else if (ce) begin
      irq_stat_q <= (stat_rd ? 2'h0 : irq_stat_q) | ev;
    end
  end

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_lat_zero_pass: assert property (
    (lat_q == 2'h0) |-> (serial_data_out == ser_bit))
    else $error("latency zero does not pass bit");
  a_sync_word: assert property (
    (load && sync_en_q) |=> (sh_q == 11'h001 && cnt_q == `LSLC_WORD_BITS))
    else $error("sync word wrong");
  a_ten_bit_fmt: assert property (
    (load && !sync_en_q && fmt_q == lslc_pkg::LSLC_FMT_10_BIT) |=>
      (sh_q[10:1] == $past(pix_data)))
    else $error("ten bit payload wrong");
  a_eight_bit_fmt: assert property (
    (load && !sync_en_q && fmt_q == lslc_pkg::LSLC_FMT_8_PLUS_CTRL) |=>
      (sh_q[10:1] == {$past(pix_ctrl), $past(pix_data[9:2])}))
    else $error("eight bit payload wrong");
  a_detect_off: assert property (
    (ce && !det_en_q && !sticky_q) |=> !flag_q)
    else $error("flag set while detect off");
  a_sticky_hold: assert property (
    (ce && sticky_q && flag_q && !clear_q) |=> flag_q)
    else $error("sticky flag dropped");
  a_clear_flag: assert property (
    (ce && sticky_q && clear_q && !mismatch) |=> !flag_q)
    else $error("clear did not drop flag");
  a_pin_read: assert property (
    (rd_go && is_mapped(s_axi_araddr) && reg_idx(s_axi_araddr) == `LSLC_IDX_ERR_FLAG) |=>
      (s_axi_rdata[0] == $past(stereo_error) && rvalid_q))
    else $error("flag read differs from pin");
  a_capture_take: assert property (
    (ce && capture) |=> (cap_q == {$past(pix_data[9:2]), $past(slave_pix)}))
    else $error("capture missed");
  a_follow_clear: assert property (
    (ce && !sticky_q && !mismatch) |=> !flag_q)
    else $error("non-sticky flag stuck");

  c_sync_load: cover property (load && sync_en_q);
  c_sticky_clear: cover property (sticky_q && flag_q ##1 clear_q);
  c_capture: cover property (ce && capture);
  c_irq: cover property ($rose(irq));

endmodule // lslc_top

// file: verilog/lslc_cfg.svh
// Register indices, field positions, reset values and sizes for the link control block
`ifndef LSLC_CFG_SVH
`define LSLC_CFG_SVH

// -----------------------------------------------------------------
// Register indices (byte address is four times the index)
// -----------------------------------------------------------------
`define LSLC_IDX_LATENCY 8'hB4
`define LSLC_IDX_SYNC 8'hB5
`define LSLC_IDX_PAYLOAD 8'hB6
`define LSLC_IDX_ERR_CTRL 8'hB7
`define LSLC_IDX_ERR_FLAG 8'hB8
`define LSLC_IDX_CAPTURE 8'hB9
`define LSLC_IDX_GAIN 8'hBA
`define LSLC_IDX_EXPOSURE 8'hBB
`define LSLC_IDX_IRQ_STAT 8'hF0
`define LSLC_IDX_IRQ_MASK 8'hF1

// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define LSLC_LAT_MSB 1
`define LSLC_BIT_SYNC_EN 0
`define LSLC_BIT_TEN_BIT 0
`define LSLC_BIT_DET_EN 0
`define LSLC_BIT_STICKY 1
`define LSLC_BIT_CLEAR 2
`define LSLC_IRQ_ERR 0
`define LSLC_IRQ_CAP 1

// -----------------------------------------------------------------
// Reset values and sizes
// -----------------------------------------------------------------
`define LSLC_GAIN_RST 7'h10
`define LSLC_EXPO_RST 16'h00C8
`define LSLC_WORD_BITS 4'hB
`define LSLC_SYNC_PAYLOAD 10'h000
`define LSLC_RESP_OKAY 2'h0
`define LSLC_RESP_SLVERR 2'h2

`endif

// file: verilog/lslc_pkg.sv
// Shared types of the link control block
package lslc_pkg;

  // Link latency choice, 0 to 3 bit times
  typedef logic [1:0] lslc_lat_t;

  // Payload format of a serial word
  typedef enum logic {
    LSLC_FMT_8_PLUS_CTRL,
    LSLC_FMT_10_BIT
  } lslc_fmt_t;

  // Serializer states
  typedef enum logic {
    LSLC_SER_IDLE,
    LSLC_SER_SHIFT
  } lslc_ser_state_t;

endpackage : lslc_pkg

// file: verilog/lslc_delay_line.sv
// Selectable bit delay that aligns the serial stream with the partner sensor
`timescale 1ns/1ps
module lslc_delay_line #(
  parameter int DEPTH = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire lslc_pkg::lslc_lat_t sel,
  input wire logic bit_in,
  output logic bit_out
);

  // -----------------------------------------------------------------
  // Delay stages
  // -----------------------------------------------------------------
  logic [DEPTH:0] tap; // Tap 0 is the undelayed bit

  assign tap[0] = bit_in;

  // One flop per stage, frozen with the clock enable
  genvar g;
  generate
    for (g = 1; g <= DEPTH; g++) begin : g_stage
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          tap[g] <= 1'b0;
        end else if (ce) begin
          tap[g] <= tap[g-1];
        end
      end
    end
  endgenerate

  // -----------------------------------------------------------------
  // Tap select
  // -----------------------------------------------------------------
  // latency tap pick
  assign bit_out = tap[sel];

endmodule // lslc_delay_line

// file: testbench/lslc_partner.sv
// Model of the second sensor answering beside each master word
`timescale 1ns/1ps
module lslc_partner (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic word_strobe,
  input wire logic [7:0] cfg_pix,
  input wire logic [1:0] cfg_ctrl,
  input wire logic cfg_reserved,
  output logic slave_valid,
  output logic [7:0] slave_pix,
  output logic [1:0] slave_ctrl,
  output logic slave_reserved
);
  // Last word shown, kept for the idle pattern
  logic [10:0] last_q;

  // Remember each word that was presented
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_q <= 11'h000;
    end else if (word_strobe) begin
      last_q <= {cfg_reserved, cfg_ctrl, cfg_pix};
    end
  end

  // Word in the same cycle as the master; idle lines show the inverse
  always_comb begin
    slave_valid = aresetn & word_strobe;
    if (slave_valid) begin
      {slave_reserved, slave_ctrl, slave_pix} = {cfg_reserved, cfg_ctrl, cfg_pix};
    end else begin
      {slave_reserved, slave_ctrl, slave_pix} = ~last_q;
    end
  end
endmodule // lslc_partner

// file: testbench/lslc_top_tb_top.sv
// Self-checking bench for the link control block
`timescale 1ns/1ps
`include "lslc_cfg.svh"
module lslc_top_tb_top;
  // -------------------------------------------------------------
  // Signals
  // -------------------------------------------------------------
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, st;
  logic pix_valid = 1'b0, pix_reserved = 1'b0, pix_ready, p_rsv = 1'b0;
  logic [9:0] pix_data = 10'h000;
  logic [1:0] pix_ctrl = 2'h0, p_ctrl = 2'h0, slave_ctrl;
  logic [7:0] p_pix = 8'h00, slave_pix;
  logic slave_valid, slave_reserved, serial_data_out, stereo_error, irq;
  logic gain_valid = 1'b0, expo_valid = 1'b0, ce = 1'b1;
  logic [6:0] gain_in = 7'h00;
  logic [15:0] expo_in = 16'h0000;
  int fail_count = 0, checks = 0;

  // Clock, 8 ns period
  always #4 aclk = ~aclk;

  lslc_top #(.ADDR_W(12), .LAT_DEPTH(3)) u_dut (
    .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pix_valid, .pix_ready,
    .pix_data, .pix_ctrl, .pix_reserved, .slave_valid, .slave_pix, .slave_ctrl,
    .slave_reserved, .gain_valid, .gain_in, .expo_valid, .expo_in, .serial_data_out,
    .stereo_error, .irq
  );

  lslc_partner u_partner (
    .aclk, .aresetn, .word_strobe(pix_valid), .cfg_pix(p_pix), .cfg_ctrl(p_ctrl),
    .cfg_reserved(p_rsv), .slave_valid, .slave_pix, .slave_ctrl, .slave_reserved
  );

  // -------------------------------------------------------------
  // Compare and bus tasks
  // -------------------------------------------------------------
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Write with both channels offered together
  task automatic axi_write(input logic [7:0] idx, input logic [31:0] data);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= {2'b00, idx, 2'b00};
    s_axi_wdata <= data;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    st = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // Read one word and compare data and response
  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_araddr <= {2'b00, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk_val(d, exp);
    chk_val({30'h0, r}, {30'h0, er});
  endtask

  // One pixel word; checks every serial bit, returns flag after it
  task automatic send_word(input logic [9:0] d, input logic [1:0] c, input logic rsv,
                           input logic [1:0] lat, input logic ten, output logic [1:0] fl);
    logic [10:0] w;
    w = ten ? {d, 1'b1} : {c, d[9:2], 1'b1};
    @(posedge aclk);
    pix_data <= d;
    pix_ctrl <= c;
    pix_reserved <= rsv;
    pix_valid <= 1'b1;
    do @(posedge aclk); while (pix_ready !== 1'b1);
    pix_valid <= 1'b0;
    for (int k = 0; k < 15; k++) begin
      @(negedge aclk);
      if (k < 2) fl[k] = stereo_error;
      if (k < lat) chk_bit(serial_data_out, 1'b0);
      else if (k - lat < 11) chk_bit(serial_data_out, w[k-lat]);
    end
  endtask

  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  task automatic t_reset();
    rd_chk(`LSLC_IDX_GAIN, 32'h10, 2'h0);
    rd_chk(`LSLC_IDX_EXPOSURE, 32'hC8, 2'h0);
    rd_chk(`LSLC_IDX_SYNC, 32'h0, 2'h0);
    rd_chk(`LSLC_IDX_PAYLOAD, 32'h0, 2'h0);
    rd_chk(`LSLC_IDX_ERR_CTRL, 32'h0, 2'h0);
    rd_chk(`LSLC_IDX_ERR_FLAG, 32'h0, 2'h0);
    rd_chk(8'h80, 32'h0, 2'h2);
    chk_bit(stereo_error, 1'b0);
  endtask

  // Every latency with both payload formats
  task automatic t_format();
    logic [1:0] fl;
    for (int l = 0; l < 4; l++) begin
      for (int t = 0; t < 2; t++) begin
        axi_write(`LSLC_IDX_LATENCY, 32'(l));
        axi_write(`LSLC_IDX_PAYLOAD, 32'(t));
        rd_chk(`LSLC_IDX_LATENCY, 32'(l), 2'h0);
        send_word(10'h2D3 ^ 10'(l), 2'(l), 1'b0, 2'(l), t[0], fl);
      end
    end
  endtask

  // Sync words repeat while pixels are refused
  task automatic t_sync();
    int n;
    axi_write(`LSLC_IDX_SYNC, 32'h1);
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (serial_data_out !== 1'b1 && n < 40);
    chk_bit(pix_ready, 1'b0);
    for (int k = 1; k <= 11; k++) begin
      @(negedge aclk);
      chk_bit(serial_data_out, k == 11);
    end
    axi_write(`LSLC_IDX_SYNC, 32'h0);
    repeat (15) @(posedge aclk);
  endtask

  // Detection gating, plain and sticky flag, clear, interrupt
  task automatic t_stereo();
    logic [1:0] fl;
    axi_write(`LSLC_IDX_PAYLOAD, 32'h0);
    p_ctrl <= 2'h1;
    send_word(10'h100, 2'h2, 1'b0, 2'h3, 1'b0, fl);
    chk_val(32'(fl), 32'h0);
    axi_write(`LSLC_IDX_ERR_CTRL, 32'h1);
    send_word(10'h104, 2'h2, 1'b0, 2'h3, 1'b0, fl);
    chk_val(32'(fl), 32'h1);
    chk_bit(irq, 1'b0);
    axi_write(`LSLC_IDX_IRQ_MASK, 32'h3);
    @(negedge aclk);
    chk_bit(irq, 1'b1);
    rd_chk(`LSLC_IDX_IRQ_STAT, 32'h1, 2'h0);
    @(negedge aclk);
    chk_bit(irq, 1'b0);
    rd_chk(`LSLC_IDX_IRQ_STAT, 32'h0, 2'h0);
    axi_write(`LSLC_IDX_ERR_CTRL, 32'h3);
    send_word(10'h108, 2'h2, 1'b0, 2'h3, 1'b0, fl);
    p_ctrl <= 2'h2;
    send_word(10'h10C, 2'h2, 1'b0, 2'h3, 1'b0, fl);
    chk_bit(stereo_error, 1'b1);
    rd_chk(`LSLC_IDX_ERR_FLAG, 32'h1, 2'h0);
    axi_write(`LSLC_IDX_ERR_CTRL, 32'h7);
    repeat (2) @(negedge aclk);
    chk_bit(stereo_error, 1'b0);
    rd_chk(`LSLC_IDX_ERR_FLAG, 32'h0, 2'h0);
    rd_chk(`LSLC_IDX_ERR_CTRL, 32'h3, 2'h0);
    axi_write(`LSLC_IDX_ERR_CTRL, 32'h0);
    rd_chk(`LSLC_IDX_IRQ_STAT, 32'h1, 2'h0);
  endtask

  // Capture only when master is reserved and slave is not
  task automatic t_capture();
    logic [1:0] fl;
    p_pix <= 8'h5A;
    send_word(10'h2C7, 2'h2, 1'b1, 2'h3, 1'b0, fl);
    rd_chk(`LSLC_IDX_CAPTURE, 32'hB15A, 2'h0);
    rd_chk(`LSLC_IDX_IRQ_STAT, 32'h2, 2'h0);
    p_rsv <= 1'b1;
    send_word(10'h0FF, 2'h2, 1'b1, 2'h3, 1'b0, fl);
    rd_chk(`LSLC_IDX_CAPTURE, 32'hB15A, 2'h0);
  endtask

  // Status updates, read-only and unmapped writes
  task automatic t_status();
    @(posedge aclk);
    gain_in <= 7'h55;
    expo_in <= 16'h1234;
    gain_valid <= 1'b1;
    expo_valid <= 1'b1;
    @(posedge aclk);
    gain_valid <= 1'b0;
    expo_valid <= 1'b0;
    rd_chk(`LSLC_IDX_GAIN, 32'h55, 2'h0);
    rd_chk(`LSLC_IDX_EXPOSURE, 32'h1234, 2'h0);
    axi_write(`LSLC_IDX_GAIN, 32'h7F);
    rd_chk(`LSLC_IDX_GAIN, 32'h55, 2'h0);
    // Clock enable low freezes the gain status
    @(posedge aclk);
    ce <= 1'b0;
    gain_in <= 7'h22;
    gain_valid <= 1'b1;
    repeat (2) @(posedge aclk);
    gain_valid <= 1'b0;
    ce <= 1'b1;
    rd_chk(`LSLC_IDX_GAIN, 32'h55, 2'h0);
    axi_write(8'h80, 32'h1);
    chk_val(32'(st), 32'h2);
  endtask

  // -------------------------------------------------------------
  // Run control
  // -------------------------------------------------------------
  task automatic test_done();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_format();
    t_sync();
    t_stereo();
    t_capture();
    t_status();
    test_done();
  end

  // Watchdog, far beyond the several hundred cycles expected
  initial begin
    #200000;
    fail_count++;
    test_done();
  end
endmodule // lslc_top_tb_top
